// File: hw/tmr_pkg.sv
package tmr_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_CTR = 16;
    localparam int DW = 32;
    localparam int SEL_W = 26;
    localparam int NUM_NET_PORT = 10;
    localparam int NUM_DIR = 5;
    localparam int IDX_W = 6;
    localparam int WA_W = 30;

    // ==========================================================
    // special-register indices
    localparam logic [IDX_W-1:0] SR_CTR_BASE = 6'h00;
    localparam logic [IDX_W-1:0] SR_FILTER = 6'h10;
    localparam logic [IDX_W-1:0] SR_SRCSEL = 6'h11;
    localparam logic [IDX_W-1:0] SR_NETMEAN = 6'h12;
    localparam logic [IDX_W-1:0] SR_TRIG = 6'h13;
    localparam logic [IDX_W-1:0] SR_WCOUNT = 6'h14;
    localparam logic [IDX_W-1:0] SR_WLIMIT = 6'h15;
    localparam logic [IDX_W-1:0] SR_WCTRL = 6'h16;
    localparam logic [IDX_W-1:0] SR_REFEN = 6'h17;
    localparam logic [IDX_W-1:0] SR_REFVAL = 6'h18;
    localparam logic [IDX_W-1:0] SR_EXCADDR = 6'h19;
    localparam logic [IDX_W-1:0] SR_XPC = 6'h1A;
    localparam logic [IDX_W-1:0] SR_FREEZE = 6'h1B;

    // ==========================================================
    // reset values and constants
    localparam logic [DW-1:0] FILTER_RST = 32'hFFFF_0000;
    localparam logic [DW-1:0] ZERO_W = 32'h0000_0000;
    localparam logic [DW-1:0] ONE_W = 32'h0000_0001;
    localparam logic [DW-1:0] ALL_ONES_W = 32'hFFFF_FFFF;
    localparam logic [DW-1:0] XPC_STEP = 32'h0000_0008;

    // ==========================================================
    // field positions
    localparam int FILT_MODE_BIT = 0;
    localparam int FILT_ADDR_LO = 1;
    localparam int FILT_ADDR_HI = 15;
    localparam int FILT_EN_LO = 16;
    localparam int WD_DYN_BIT = 0;
    localparam int WD_RUN_BIT = 1;
    localparam int WD_IRQ_BIT = 2;
    localparam int WD_CTRL_W = 3;
    localparam int WORD_LO = 2;
    localparam int SW_HALF_BIT = 2;
    localparam int NET_CODE_W = 3;

    // ==========================================================
    // event routing tables
    localparam logic [NUM_CTR-1:0] CTR_PRIM = 16'h07FF;
    localparam logic [NUM_CTR-1:0] CTR_HAS_CHOICE = 16'h0071;
    localparam logic [NUM_CTR-1:0] PRIM_NOPC = 16'h0781;
    localparam logic [SEL_W-1:0] SEL_NOPC = 26'h1E1_8DB0;

    localparam logic [NET_CODE_W-1:0] NET_OUT_BLOCKED = 3'h0;
    localparam logic [NET_CODE_W-1:0] NET_MOVED_LO = 3'h1;
    localparam logic [NET_CODE_W-1:0] NET_IN_ALL = 3'h6;
    localparam logic [NET_CODE_W-1:0] NET_IN_STALL = 3'h7;

    // choice bit that picks the alternative event of a counter
    function automatic int choiceBit(input int i);
        case (i)
            0: choiceBit = 25;
            4: choiceBit = 0;
            5: choiceBit = 1;
            6: choiceBit = 2;
            default: choiceBit = 0;
        endcase
    endfunction : choiceBit

    // source-select bits that are or-ed into a counter
    function automatic logic [SEL_W-1:0] grpMask(input int i);
        case (i)
            11: grpMask = 26'h080_0038;
            12: grpMask = 26'h000_01C0;
            13: grpMask = 26'h100_0E00;
            14: grpMask = 26'h001_F000;
            15: grpMask = 26'h07E_0000;
            default: grpMask = 26'h000_0000;
        endcase
    endfunction : grpMask

    // port n = net*5 + dir, dir order processor, west, south, east, north
    function automatic int netSelBit(input int n);
        case (n)
            0: netSelBit = 4;
            1: netSelBit = 7;
            2: netSelBit = 10;
            3: netSelBit = 15;
            4: netSelBit = 21;
            5: netSelBit = 5;
            6: netSelBit = 8;
            7: netSelBit = 11;
            8: netSelBit = 16;
            default: netSelBit = 22;
        endcase
    endfunction : netSelBit

    // ==========================================================
    // carriers
    typedef struct packed {
        logic outBlocked;
        logic [NUM_DIR-1:0] moved;
        logic inStalled;
    } tmr_port_act_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [IDX_W-1:0] idx;
        logic [DW-1:0] data;
    } tmr_sr_req_t;

    typedef enum logic [0:0] {
        RF_IDLE,
        RF_EXC
    } tmr_rf_state_t;
endpackage : tmr_pkg

// File: hw/tmr_event_ctr.sv
module tmr_event_ctr
    import tmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic load,
    input wire logic [DW-1:0] loadVal,
    input wire logic dec,
    output logic [DW-1:0] count,
    output logic trig
);
    typedef struct packed {
        logic [DW-1:0] count;
        logic trig;
    } tmr_ctr_st_t;

    tmr_ctr_st_t st_q;
    tmr_ctr_st_t st_d;

    // ==========================================================
    // count down; a write wins over a same-cycle event
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.count = loadVal;
            st_d.trig = 1'b0; // see [R2]
        end else if (dec) begin
            st_d.count = st_q.count - ONE_W; // see [R1]
            if (st_q.count == ZERO_W) begin
                st_d.trig = 1'b1; // see [R2]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign count = st_q.count;
    assign trig = st_q.trig;

    a_trig_on_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R2]
        (ce && !load && dec && count == ZERO_W) |=> (trig && count == ALL_ONES_W))
        else $error("trigger missing after wrap to minus one");

    a_trig_held: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R2]
        (trig && !(ce && load)) |=> trig)
        else $error("trigger dropped without a counter write");
endmodule : tmr_event_ctr

// File: hw/tmr_net_event.sv
module tmr_net_event
    import tmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [NET_CODE_W-1:0] code,
    input tmr_port_act_t [NUM_NET_PORT-1:0] act,
    output logic [NUM_NET_PORT-1:0] evt
);
    // ==========================================================
    // one decoder per network and direction, all sharing one code
    for (genvar n = 0; n < NUM_NET_PORT; n++) begin : g_port
        always_comb begin
            case (code) // see [R9]
                NET_OUT_BLOCKED: evt[n] = act[n].outBlocked; // see [R10]
                NET_IN_ALL: evt[n] = |act[n].moved; // see [R12]
                NET_IN_STALL: evt[n] = act[n].inStalled; // see [R12]
                default: evt[n] = act[n].moved[code - NET_MOVED_LO]; // see [R11]
            endcase
        end

        a_code_all: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
            (code == NET_IN_ALL) |-> (evt[n] == (|act[n].moved)))
            else $error("all-words code does not follow port activity");
    end
endmodule : tmr_net_event

// File: hw/tmr_monitor_ctl.sv
// Operation
// [R1] sixteen 32-bit counters, each decrementing on its selected event
// [R2] trigger sets on zero to minus one, held until counter rewritten
// [R3] counter fifteen counts general/memory north port events via bits 21, 22
// [R4] filter bit zero limits counting to the instruction at bits 15..1
// [R5] events without an instruction address ignore the single-instruction filter
// [R6] high filter bits enable each counter; clearing keeps existing triggers
// [R7] shared-entry alternatives: the select bit picks exactly one event
// [R8] separate entries on one counter: set select bits or their events together
// [R9] port events qualified by network and direction, meaning from one code
// [R10] code 0 counts output-blocked cycles toward the neighbour
// [R11] codes 1-5 count words to processor, west, south, east, north
// [R12] code 6 counts all words leaving input; code 7 input stalls
// [R13] exception return restores saved address and enables interrupts together
// [R14] frozen switch holds its program counter and performs no routes
// [R15] switch program counter readable and writable at any time
// [R16] processor imem access stalls processor one cycle, word addressed
// [R17] switch imem access stalls switch one cycle, frozen or not
// [R18] switch instructions 64-bit; opcode word sits at address ending 100b
// [R19] watchdog count increments every cycle regardless of stalls
// [R20] watch event when count reaches the programmed limit
// [R21] control bit 0 clears count on dynamic network or refill removal
// [R22] control bit 1 clears count on unstalled cycles; bits reset zero
// [R23] refill mode: dynamic read returns refill value then raises exception
// [R24] refill reads clear the enabled watchdog like real reads
// [R25] enabled watch events become a watchdog interrupt request
// [R26] handler reloads refill value or clears refill mode before returning
module tmr_monitor_ctl
    import tmr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input tmr_sr_req_t srReq,
    output logic [DW-1:0] srRdData,
    output logic srRdValid,
    input wire logic [NUM_CTR-1:0] evtPrim,
    input wire logic [NUM_CTR-1:0] evtAlt,
    input wire logic [SEL_W-1:0] evtOr,
    input wire logic [FILT_ADDR_HI-FILT_ADDR_LO:0] instrWordAddr,
    input tmr_port_act_t [NUM_NET_PORT-1:0] netAct,
    output logic [NUM_CTR-1:0] ctrTrig,
    output logic ctrAnyTrig,
    input wire logic cpuStalled,
    input wire logic dynRemove,
    input wire logic dynRead,
    input wire logic [DW-1:0] dynNetData,
    output logic [DW-1:0] dynReadData,
    output logic dynFromRefill,
    output logic refillExc,
    output logic watchEvt,
    output logic watchIrq,
    input wire logic excTake,
    input wire logic [DW-1:0] excPc,
    input wire logic eretReq,
    output logic resumeRedirect,
    output logic [DW-1:0] resumePc,
    output logic intEnable,
    input wire logic swStep,
    output logic swFrozen,
    output logic swRouteEn,
    output logic [DW-1:0] swPc,
    input wire logic procImemReq,
    input wire logic swImemReq,
    input wire logic imemWe,
    input wire logic [DW-1:0] imemAddr,
    output logic procStall,
    output logic procImemWr,
    output logic [WA_W-1:0] procImemWordAddr,
    output logic swStall,
    output logic swImemWr,
    output logic [WA_W-1:0] swImemWordAddr,
    output logic swImemOpcodeWord
);
    typedef struct packed {
        logic [DW-1:0] filter;
        logic [DW-1:0] srcSel;
        logic [NET_CODE_W-1:0] netMean;
        logic [DW-1:0] wCount;
        logic [DW-1:0] wLimit;
        logic [WD_CTRL_W-1:0] wCtrl;
        logic refEn;
        logic [DW-1:0] refVal;
        logic [DW-1:0] excAddr;
        logic [DW-1:0] xpc;
        logic freeze;
        logic [DW-1:0] rdData;
        logic rdValid;
        logic [DW-1:0] dynData;
        logic dynFromRef;
        tmr_rf_state_t refState;
        logic refExc;
        logic watchEvt;
        logic watchIrq;
        logic redirect;
        logic [DW-1:0] resumePc;
        logic intEn;
        logic routeEn;
        logic procStall;
        logic procWr;
        logic [WA_W-1:0] procWa;
        logic swStall;
        logic swWr;
        logic [WA_W-1:0] swWa;
        logic swOpWord;
        logic anyTrig;
    } tmr_main_st_t;

    localparam tmr_main_st_t ST_RST = '{filter: FILTER_RST, refState: RF_IDLE, default: '0};

    tmr_main_st_t st_q;
    tmr_main_st_t st_d;
    logic [NUM_NET_PORT-1:0] netEvt;
    logic [SEL_W-1:0] selEvt;
    logic [NUM_CTR-1:0] ctrLoad;
    logic [NUM_CTR-1:0] ctrDec;
    logic [NUM_CTR-1:0] ctrTrigW;
    logic [DW-1:0] ctrVal [NUM_CTR];
    logic addrPass;
    logic wdClear;
    logic wrWCount;
    logic wrXpc;

    // ==========================================================
    // network port event decode
    tmr_net_event u_net (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .code(st_q.netMean),
        .act(netAct),
        .evt(netEvt)
    );

    // port events take the place of their select positions in the event vector
    always_comb begin
        selEvt = evtOr;
        for (int n = 0; n < NUM_NET_PORT; n++) begin
            selEvt[netSelBit(n)] = netEvt[n]; // see [R3]
        end
    end

    // single-instruction filter; only events carrying an address are gated
    assign addrPass = !st_q.filter[FILT_MODE_BIT]
        || (instrWordAddr == st_q.filter[FILT_ADDR_HI:FILT_ADDR_LO]); // see [R4]

    // ==========================================================
    // event counters
    for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
        logic choice;
        logic baseEv;
        logic baseFree;
        logic grpAddr;
        logic grpFree;
        logic hit;

        assign choice = CTR_HAS_CHOICE[i] && st_q.srcSel[choiceBit(i)]; // see [R7]
        assign baseEv = CTR_PRIM[i] && (choice ? evtAlt[i] : evtPrim[i]); // see [R7]
        assign baseFree = !choice && PRIM_NOPC[i];
        assign grpAddr = |(st_q.srcSel[SEL_W-1:0] & grpMask(i) & selEvt & ~SEL_NOPC); // see [R8]
        assign grpFree = |(st_q.srcSel[SEL_W-1:0] & grpMask(i) & selEvt & SEL_NOPC); // see [R8]
        assign hit = (baseEv && (baseFree || addrPass)) || (grpAddr && addrPass)
            || grpFree; // see [R5]
        assign ctrDec[i] = hit && st_q.filter[FILT_EN_LO + i]; // see [R6]
        assign ctrLoad[i] = srReq.wr && (srReq.idx == SR_CTR_BASE + IDX_W'(i));

        tmr_event_ctr u_ctr (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .ce(ce),
            .load(ctrLoad[i]),
            .loadVal(srReq.data),
            .dec(ctrDec[i]),
            .count(ctrVal[i]),
            .trig(ctrTrigW[i])
        );
    end

    // watchdog clear terms; a refill read counts as a removal
    assign wdClear = (st_q.wCtrl[WD_DYN_BIT] && (dynRemove || (dynRead && st_q.refEn)))
        || (st_q.wCtrl[WD_RUN_BIT] && !cpuStalled); // see [R21] see [R22] see [R24]
    assign wrWCount = srReq.wr && srReq.idx == SR_WCOUNT;
    assign wrXpc = srReq.wr && srReq.idx == SR_XPC;

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        // register writes
        if (srReq.wr) begin
            case (srReq.idx)
                SR_FILTER: st_d.filter = srReq.data;
                SR_SRCSEL: st_d.srcSel = srReq.data;
                SR_NETMEAN: st_d.netMean = srReq.data[NET_CODE_W-1:0];
                SR_WLIMIT: st_d.wLimit = srReq.data;
                SR_WCTRL: st_d.wCtrl = srReq.data[WD_CTRL_W-1:0];
                SR_REFEN: st_d.refEn = srReq.data[0];
                SR_REFVAL: st_d.refVal = srReq.data;
                SR_FREEZE: st_d.freeze = srReq.data[0];
                default: st_d.freeze = st_q.freeze;
            endcase
        end
        // register reads, one cycle after the request
        st_d.rdValid = srReq.rd;
        st_d.rdData = ZERO_W;
        if (srReq.idx < SR_FILTER) begin
            st_d.rdData = ctrVal[srReq.idx[3:0]];
        end else begin
            case (srReq.idx)
                SR_FILTER: st_d.rdData = st_q.filter;
                SR_SRCSEL: st_d.rdData = st_q.srcSel;
                SR_NETMEAN: st_d.rdData = DW'(st_q.netMean);
                SR_TRIG: st_d.rdData = DW'(ctrTrigW);
                SR_WCOUNT: st_d.rdData = st_q.wCount;
                SR_WLIMIT: st_d.rdData = st_q.wLimit;
                SR_WCTRL: st_d.rdData = DW'(st_q.wCtrl);
                SR_REFEN: st_d.rdData = DW'(st_q.refEn);
                SR_REFVAL: st_d.rdData = st_q.refVal;
                SR_EXCADDR: st_d.rdData = st_q.excAddr;
                SR_XPC: st_d.rdData = st_q.xpc; // see [R15]
                SR_FREEZE: st_d.rdData = DW'(st_q.freeze);
                default: st_d.rdData = ZERO_W;
            endcase
        end
        st_d.anyTrig = |ctrTrigW;

        // watchdog: software write, then clear, else free-running increment
        if (wrWCount) begin
            st_d.wCount = srReq.data;
        end else if (wdClear) begin
            st_d.wCount = ZERO_W; // see [R21] see [R22]
        end else begin
            st_d.wCount = st_q.wCount + ONE_W; // see [R19]
        end
        st_d.watchEvt = (st_q.wCount == st_q.wLimit); // see [R20]
        st_d.watchIrq = st_d.watchEvt && st_q.wCtrl[WD_IRQ_BIT]; // see [R25]

        // dynamic read path and refill exception sequencing
        st_d.refExc = 1'b0;
        case (st_q.refState)
            RF_IDLE: begin
                if (dynRead && st_q.refEn) begin
                    st_d.refState = RF_EXC;
                end
            end
            RF_EXC: begin
                st_d.refExc = 1'b1; // see [R23]
                st_d.refState = RF_IDLE;
            end
            default: st_d.refState = RF_IDLE;
        endcase
        if (dynRead) begin
            st_d.dynData = st_q.refEn ? st_q.refVal : dynNetData; // see [R23]
            st_d.dynFromRef = st_q.refEn;
        end

        // exception entry and atomic return
        st_d.redirect = 1'b0;
        if (excTake) begin
            st_d.excAddr = excPc;
            st_d.intEn = 1'b0;
        end else if (eretReq) begin
            st_d.redirect = 1'b1; // see [R13]
            st_d.resumePc = st_q.excAddr;
            st_d.intEn = 1'b1; // see [R13]
        end else if (srReq.wr && srReq.idx == SR_EXCADDR) begin
            st_d.excAddr = srReq.data;
        end

        // switch sequencing; an imem access steals the next switch cycle
        if (wrXpc) begin
            st_d.xpc = srReq.data; // see [R15]
        end else if (swStep && st_q.routeEn) begin
            st_d.xpc = st_q.xpc + XPC_STEP; // see [R14]
        end
        st_d.routeEn = !st_d.freeze && !swImemReq; // see [R14] see [R17]

        // instruction memory access, word addressed, low bits dropped
        st_d.procStall = procImemReq; // see [R16]
        st_d.procWr = procImemReq && imemWe;
        if (procImemReq) begin
            st_d.procWa = imemAddr[DW-1:WORD_LO]; // see [R16]
        end
        st_d.swStall = swImemReq; // see [R17]
        st_d.swWr = swImemReq && imemWe;
        if (swImemReq) begin
            st_d.swWa = imemAddr[DW-1:WORD_LO];
            st_d.swOpWord = imemAddr[SW_HALF_BIT]; // see [R18]
        end
    end

    // clock enable freezes every flop of the block
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs
    assign srRdData = st_q.rdData;
    assign srRdValid = st_q.rdValid;
    assign ctrTrig = ctrTrigW;
    assign ctrAnyTrig = st_q.anyTrig;
    assign dynReadData = st_q.dynData;
    assign dynFromRefill = st_q.dynFromRef;
    assign refillExc = st_q.refExc;
    assign watchEvt = st_q.watchEvt;
    assign watchIrq = st_q.watchIrq;
    assign resumeRedirect = st_q.redirect;
    assign resumePc = st_q.resumePc;
    assign intEnable = st_q.intEn;
    assign swFrozen = st_q.freeze;
    assign swRouteEn = st_q.routeEn;
    assign swPc = st_q.xpc;
    assign procStall = st_q.procStall;
    assign procImemWr = st_q.procWr;
    assign procImemWordAddr = st_q.procWa;
    assign swStall = st_q.swStall;
    assign swImemWr = st_q.swWr;
    assign swImemWordAddr = st_q.swWa;
    assign swImemOpcodeWord = st_q.swOpWord;

    // ==========================================================
    // checks
    a_refill_seq: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R23]
        (ce && dynRead && st_q.refEn && st_q.refState == RF_IDLE) ##1 ce
        |-> (dynFromRefill && dynReadData == $past(st_q.refVal)) ##1 refillExc)
        else $error("refill read not followed by refill exception");

    a_watch_inc: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R19]
        (ce && !wrWCount && !wdClear) |=> (st_q.wCount == $past(st_q.wCount) + ONE_W))
        else $error("watchdog count did not advance");

    a_watch_runclr: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R22]
        (ce && !wrWCount && st_q.wCtrl[WD_RUN_BIT] && !cpuStalled) |=> st_q.wCount == ZERO_W)
        else $error("watchdog not cleared on unstalled cycle");

    a_watch_event: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R20]
        (ce && st_q.wCount == st_q.wLimit)
        |=> (watchEvt && watchIrq == $past(st_q.wCtrl[WD_IRQ_BIT])))
        else $error("watch event or interrupt wrong at limit");

    a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R14]
        (ce && swFrozen && !wrXpc && !(srReq.wr && srReq.idx == SR_FREEZE))
        |=> ($stable(swPc) && !swRouteEn))
        else $error("frozen switch advanced");

    a_eret_atomic: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R13]
        (ce && eretReq && !excTake)
        |=> (resumeRedirect && intEnable && resumePc == $past(st_q.excAddr)))
        else $error("exception return not atomic");

    a_proc_stall: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R16]
        (ce && procImemReq) |=> (procStall && procImemWordAddr == $past(imemAddr[DW-1:WORD_LO])))
        else $error("processor imem access did not stall");

    a_sw_opword: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R17]
        (ce && swImemReq)
        |=> (swStall && !swRouteEn && swImemOpcodeWord == $past(imemAddr[SW_HALF_BIT])))
        else $error("switch imem access wrong");
endmodule : tmr_monitor_ctl

// File: dv/tmr_far_model.sv
module tmr_far_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    output logic swStep,
    output logic [31:0] dynNetData
);
    timeunit 1ns;
    timeprecision 1ps;
    // net word moves every cycle so a stale sample cannot match
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dynNetData <= 32'h0000_0000;
        end else begin
            dynNetData <= dynNetData + 32'h1357_9BDF;
        end
    end
    assign swStep = rst_n; // switch always wants to sequence
endmodule : tmr_far_model

// File: dv/tb_top.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch %0t %h vs %h", $time, a, b); end end
module tb_top
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [5:0] idx; logic [31:0] wd; logic [31:0] ex;} tmr_row_t;
    logic ref_clk = 0, rst_n = 0, ce = 1, srRdValid, ctrAnyTrig, cpuStalled = 0;
    logic dynRead = 0, dynRemove = 0, dynFromRefill, refillExc, watchEvt, watchIrq;
    logic excTake = 0, eretReq = 0, resumeRedirect, intEnable, swStep, swFrozen;
    logic swRouteEn, procImemReq = 0, swImemReq = 0, imemWe = 0, procStall;
    logic procImemWr, swStall, swImemWr, swImemOpcodeWord;
    logic [DW-1:0] srRdData, dynNetData, dynReadData, resumePc, swPc, snap;
    logic [DW-1:0] excPc = '0, imemAddr = '0;
    logic [NUM_CTR-1:0] evtPrim = '0, evtAlt = '0, ctrTrig;
    logic [SEL_W-1:0] evtOr = '0;
    logic [14:0] instrWordAddr = '0;
    logic [WA_W-1:0] procImemWordAddr, swImemWordAddr;
    tmr_port_act_t [NUM_NET_PORT-1:0] netAct = '0;
    tmr_sr_req_t srReq = '0;
    int miscompares = 0, compares = 0, i;
    tmr_row_t rows[7] = '{'{SR_FREEZE, ONE_W, ONE_W},
        '{SR_XPC, 32'h0000_0100, 32'h0000_0100}, '{SR_NETMEAN, ALL_ONES_W, 32'h0000_0007},
        '{SR_WCTRL, ALL_ONES_W, 32'h0000_0007}, '{SR_REFVAL, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
        '{SR_TRIG, ALL_ONES_W, ZERO_W}, '{6'h3F, ALL_ONES_W, ZERO_W}};

    tmr_monitor_ctl u_dut (.*);
    tmr_far_model u_far (.ref_clk(ref_clk), .rst_n(rst_n), .swStep(swStep),
        .dynNetData(dynNetData));

    always #2 ref_clk = ~ref_clk;

    // ==========================================================
    // bus tasks
    task automatic wr(input logic [5:0] x, input logic [DW-1:0] d);
        @(negedge ref_clk);
        srReq = '{1'b1, 1'b0, x, d};
        @(negedge ref_clk);
        srReq = '0;
    endtask : wr
    task automatic rd(input logic [5:0] x, input logic [DW-1:0] e);
        @(negedge ref_clk);
        srReq = '{1'b0, 1'b1, x, ZERO_W};
        @(negedge ref_clk);
        srReq = '0;
        `CHK(srRdValid, 1'b1)
        `CHK(srRdData, e)
    endtask : rd
    task automatic wrap_up;
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1;
        rd(SR_FILTER, FILTER_RST);
        rd(SR_WCTRL, ZERO_W);
        // frozen switch row guards the pc row against stepping
        foreach (rows[k]) begin
            wr(rows[k].idx, rows[k].wd);
            rd(rows[k].idx, rows[k].ex);
        end
        wr(6'h01, ONE_W);
        evtPrim[1] = 1;
        repeat (2) @(negedge ref_clk);
        evtPrim[1] = 0;
        `CHK(ctrTrig[1], 1'b1)
        wr(SR_FILTER, ZERO_W);
        rd(6'h01, ALL_ONES_W);
        `CHK(ctrTrig[1], 1'b1)
        // refill read, then handler turns refill off
        wr(SR_REFEN, ONE_W);
        dynRead = 1;
        @(negedge ref_clk) dynRead = 0;
        `CHK(dynReadData, 32'hA5A5_5A5A)
        `CHK(dynFromRefill, 1'b1)
        @(negedge ref_clk) `CHK(refillExc, 1'b1)
        wr(SR_REFEN, ZERO_W);
        snap = dynNetData;
        dynRead = 1;
        @(negedge ref_clk) dynRead = 0;
        `CHK(dynReadData, snap)
        `CHK(dynFromRefill, 1'b0)
        // stalled core keeps the count running to the limit
        cpuStalled = 1;
        wr(SR_WCTRL, 32'h0000_0006);
        wr(SR_WLIMIT, 32'h0000_0014);
        wr(SR_WCOUNT, ZERO_W);
        i = 1;
        while (watchEvt !== 1'b1 && i < 60) begin
            @(negedge ref_clk);
            i++;
        end
        `CHK(i, 22)
        `CHK(watchEvt, 1'b1)
        `CHK(watchIrq, 1'b1)
        cpuStalled = 0;
        rd(SR_WCOUNT, ZERO_W);
        // only a removal clears now; without it the read would see two
        wr(SR_WCTRL, ONE_W);
        dynRemove = 1;
        @(negedge ref_clk) dynRemove = 0;
        rd(SR_WCOUNT, ONE_W);
        imemWe = 1;
        imemAddr = 32'h0000_0167;
        procImemReq = 1;
        @(negedge ref_clk) procImemReq = 0;
        `CHK(procStall, 1'b1)
        `CHK(procImemWr, 1'b1)
        `CHK(procImemWordAddr, 30'h0000_0059)
        imemAddr = 32'h0000_016C;
        swImemReq = 1;
        @(negedge ref_clk) swImemReq = 0;
        `CHK(swStall, 1'b1)
        `CHK(swImemWr, 1'b1)
        `CHK(swFrozen, 1'b1)
        `CHK(swImemWordAddr, 30'h0000_005B)
        `CHK(swImemOpcodeWord, 1'b1)
        excPc = 32'h0000_0400;
        excTake = 1;
        @(negedge ref_clk) excTake = 0;
        eretReq = 1;
        @(negedge ref_clk) eretReq = 0;
        `CHK(resumeRedirect, 1'b1)
        `CHK(resumePc, 32'h0000_0400)
        `CHK(intEnable, 1'b1)
        // counters 1, 4 and 15 on, single-instruction mode at word address one
        wr(SR_FILTER, 32'h8012_0003);
        wr(SR_SRCSEL, 32'h0020_0001);
        wr(SR_NETMEAN, 32'h0000_0006);
        wr(6'h01, 32'h0000_0005);
        wr(6'h0F, 32'h0000_0002);
        evtPrim[1] = 1;
        netAct[4].moved = 5'h02;
        repeat (3) @(negedge ref_clk);
        netAct[4] = '0;
        netAct[9].moved = 5'h01;
        @(negedge ref_clk) netAct[9] = '0;
        instrWordAddr = 15'h0001;
        evtAlt[4] = 1;
        @(negedge ref_clk) evtPrim[1] = 0;
        evtAlt[4] = 0;
        rd(6'h0F, ALL_ONES_W);
        rd(6'h01, 32'h0000_0004);
        rd(6'h04, ALL_ONES_W);
        `CHK(ctrTrig[15], 1'b1)
        `CHK(ctrAnyTrig, 1'b1)
        // unfreeze, then drop the clock enable: the pc may not step until it returns
        wr(SR_FREEZE, ZERO_W);
        ce = 0;
        repeat (2) @(negedge ref_clk);
        `CHK(swPc, 32'h0000_0100)
        `CHK(swRouteEn, 1'b1)
        ce = 1;
        @(negedge ref_clk) `CHK(swPc, 32'h0000_0108)
        wrap_up();
    end
endmodule : tb_top
